// *** src/hpsi_top.sv ***
// Host port selection, interrupt pin and status indicator drivers
//
// Contract
// - Reset: indicator A link, B activity.
// - Receive activity shown for every detected packet.
// - Indicator lit means output driven high.
// - Indicators run without any host access.
// - Both fields 1111 or 1110 select bi-colour.
// - Bi-colour: lit on link, colour, blink.
// - 100 full idle: B high, A low.
// - Interrupt pin low while an enabled event pending.
// - Interrupt pin always driven after strap.
// - Rx, tx, operation, wake events interrupt.
// - Exactly one host port enabled once the strap is taken, none before.
// - Strap sampled once after reset delay.
// - High selects serial, low selects parallel.
// - Serial output undriven while select high.
// - Serial mode: parallel pins off except straps.
// - Parallel data pins input when unselected.
module hpsi_top #(
    parameter int TICK_CYCLES = hpsi_pkg::TICK_CYCLES,
    parameter int BLINK_TICKS = hpsi_pkg::BLINK_TICKS,
    parameter int STRAP_CYCLES = hpsi_pkg::STRAP_DELAY_CYCLES,
    parameter int AD_WIDTH = 16
) (
    input wire logic clock,
    input wire logic sys_rst,
    // Indicator control register access
    input wire logic indicator_cfg_wr,
    input wire logic [hpsi_pkg::CTRL_WIDTH-1:0] indicator_cfg_wdata,
    output logic [hpsi_pkg::CTRL_WIDTH-1:0] indicator_control_reg,
    // PHY status
    input wire logic link_up,
    input wire logic speed_100,
    input wire logic full_duplex,
    input wire logic tx_activity,
    input wire logic rx_activity,
    // Indicator pins
    output logic indicator_a,
    output logic indicator_b,
    // Interrupt events and control
    input wire logic [hpsi_pkg::INT_SRC_COUNT-1:0] int_event,
    input wire logic [hpsi_pkg::INT_SRC_COUNT-1:0] int_enable,
    input wire logic [hpsi_pkg::INT_SRC_COUNT-1:0] int_clear,
    output logic [hpsi_pkg::INT_SRC_COUNT-1:0] int_flags,
    // Shared interrupt / select pin
    input wire logic int_pin_i,
    output logic int_n_o,
    output logic int_n_oe,
    // Host port selection status
    output logic serial_enable,
    output logic parallel_enable,
    // Serial port
    input wire logic spi_cs_n,
    input wire logic spi_so_data,
    output logic spi_so_o,
    output logic spi_so_oe,
    // Parallel port
    input wire logic par_cs,
    input wire logic par_read,
    input wire logic [AD_WIDTH-1:0] par_ad_data,
    output logic [AD_WIDTH-1:0] par_ad_o,
    output logic par_ad_oe,
    output logic par_in_en,
    input wire logic parallel_mode_strap_2,
    input wire logic parallel_mode_strap_3,
    output logic parallel_mode_strap_2_q,
    output logic parallel_mode_strap_3_q
);
    localparam int TW = $clog2(TICK_CYCLES + 1);

    logic [hpsi_pkg::CFG_WIDTH-1:0] indicator_a_config;
    logic [hpsi_pkg::CFG_WIDTH-1:0] indicator_b_config;
    logic [TW-1:0] tick_count;
    logic tick_en;
    logic [1:0] act_event;
    logic [1:0] act_seen;
    logic tx_seen;
    logic rx_seen;
    logic serial_selected;
    logic select_valid;
    logic pin_release;
    logic bicolor;
    logic colour_b;
    logic bicolor_lit;
    logic next_indicator_a;
    logic next_indicator_b;
    logic [hpsi_pkg::INT_SRC_COUNT-1:0] next_int_flags;
    logic int_pending;

    if (TICK_CYCLES < 2 || AD_WIDTH < 8) begin : g_bad_param
        $error("TICK_CYCLES must be at least 2 and AD_WIDTH at least 8");
    end

    // Indicator configuration; reset leaves link on A, activity on B
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            indicator_a_config <= hpsi_pkg::CFG_A_RST;
            indicator_b_config <= hpsi_pkg::CFG_B_RST;
        end else if (indicator_cfg_wr) begin
            indicator_a_config <= indicator_cfg_wdata[hpsi_pkg::CFG_A_LSB +: hpsi_pkg::CFG_WIDTH];
            indicator_b_config <= indicator_cfg_wdata[hpsi_pkg::CFG_B_LSB +: hpsi_pkg::CFG_WIDTH];
        end
    end

    // Readback of the control register; low byte reads zero
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            indicator_control_reg <= {hpsi_pkg::CFG_A_RST, hpsi_pkg::CFG_B_RST, 8'h00};
        end else if (indicator_cfg_wr) begin
            indicator_control_reg <= {indicator_cfg_wdata[15:8], 8'h00};
        end
    end

    // Slow tick for blink timing, free running from reset
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tick_count <= '0;
            tick_en <= 1'b0;
        end else if (tick_count == TW'(TICK_CYCLES - 1)) begin
            tick_count <= '0;
            tick_en <= 1'b1;
        end else begin
            tick_count <= tick_count + 1'b1;
            tick_en <= 1'b0;
        end
    end

    // Raw activity goes straight in; packet validity is never consulted
    assign act_event[0] = tx_activity;
    assign act_event[1] = rx_activity;

    // One stretcher per direction so short frames remain visible
    for (genvar ch = 0; ch < 2; ch++) begin : g_act
        hpsi_stretch #(
            .TICKS(BLINK_TICKS)
        ) u_stretch (
            .clock(clock),
            .sys_rst(sys_rst),
            .tick_en(tick_en),
            .event_in(act_event[ch]),
            .active(act_seen[ch])
        );
    end

    assign tx_seen = act_seen[0];
    assign rx_seen = act_seen[1];

    // Single colour decode of one configuration field
    function automatic logic ind_decode(
        input logic [3:0] cfg,
        input logic link,
        input logic spd,
        input logic dup,
        input logic tx,
        input logic rx
    );
        logic lit;
        lit = 1'b0;
        case (cfg)
            hpsi_pkg::IND_OFF: lit = 1'b0;
            hpsi_pkg::IND_ON: lit = 1'b1;
            hpsi_pkg::IND_LINK: lit = link;
            hpsi_pkg::IND_TX: lit = tx;
            hpsi_pkg::IND_RX: lit = rx;
            hpsi_pkg::IND_TXRX: lit = tx | rx;
            hpsi_pkg::IND_DUPLEX: lit = link & dup;
            hpsi_pkg::IND_SPEED: lit = link & spd;
            hpsi_pkg::IND_LINK_ACT: lit = link & ~(tx | rx);
            default: lit = 1'b0;
        endcase
        return lit;
    endfunction

    // Bi-colour needs both fields equal to one of the two special codes
    assign bicolor = (indicator_a_config == indicator_b_config) &&
        (indicator_a_config == hpsi_pkg::IND_BICOLOR_FULL ||
         indicator_a_config == hpsi_pkg::IND_BICOLOR_SPEED);

    // Colour: code F needs 100 full for side B, code E only 100
    assign colour_b = (indicator_a_config == hpsi_pkg::IND_BICOLOR_FULL) ?
        (speed_100 & full_duplex) : speed_100;

    // Lit only with link; any activity blanks the pair
    assign bicolor_lit = link_up & ~(tx_seen | rx_seen);

    // Pin level choice; high always means lit
    always_comb begin
        if (bicolor) begin
            next_indicator_a = bicolor_lit & ~colour_b;
            next_indicator_b = bicolor_lit & colour_b;
        end else begin
            next_indicator_a = ind_decode(indicator_a_config, link_up, speed_100,
                full_duplex, tx_seen, rx_seen);
            next_indicator_b = ind_decode(indicator_b_config, link_up, speed_100,
                full_duplex, tx_seen, rx_seen);
        end
    end

    // Indicator pins registered; active high sourcing drive
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            indicator_a <= 1'b0;
            indicator_b <= 1'b0;
        end else begin
            indicator_a <= next_indicator_a;
            indicator_b <= next_indicator_b;
        end
    end

    // Sticky flags; an event in the clear cycle wins over the clear
    always_comb begin
        next_int_flags = (int_flags & ~int_clear) | int_event;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            int_flags <= '0;
        end else begin
            int_flags <= next_int_flags;
        end
    end

    // Masked flags feed the pin; status stays readable for polling hosts
    assign int_pending = |(int_flags & int_enable);

    hpsi_strap_sampler #(
        .DELAY_CYCLES(STRAP_CYCLES)
    ) u_strap (
        .clock(clock),
        .sys_rst(sys_rst),
        .strap_level(int_pin_i),
        .serial_selected(serial_selected),
        .select_valid(select_valid),
        .pin_release(pin_release)
    );

    // Shared pin: floats for the strap, then driven, idle high
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            int_n_o <= 1'b1;
            int_n_oe <= 1'b0;
        end else begin
            int_n_o <= ~(pin_release & int_pending);
            int_n_oe <= pin_release;
        end
    end

    // Port enables; neither is on until the strap is known
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            serial_enable <= 1'b0;
            parallel_enable <= 1'b0;
        end else begin
            serial_enable <= select_valid & serial_selected;
            parallel_enable <= select_valid & ~serial_selected;
        end
    end

    // Serial output drives only while selected and chip select low
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            spi_so_o <= 1'b0;
            spi_so_oe <= 1'b0;
        end else begin
            spi_so_o <= spi_so_data;
            spi_so_oe <= select_valid & serial_selected & ~spi_cs_n;
        end
    end

    // Parallel data drive and input buffers; off in serial mode
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            par_ad_o <= '0;
            par_ad_oe <= 1'b0;
            par_in_en <= 1'b0;
        end else begin
            par_ad_o <= par_ad_data;
            par_ad_oe <= select_valid & ~serial_selected & par_cs & par_read;
            par_in_en <= select_valid & ~serial_selected;
        end
    end

    // Mode strap pins keep their input buffers in every mode
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            parallel_mode_strap_2_q <= 1'b0;
            parallel_mode_strap_3_q <= 1'b0;
        end else begin
            parallel_mode_strap_2_q <= parallel_mode_strap_2;
            parallel_mode_strap_3_q <= parallel_mode_strap_3;
        end
    end

endmodule

// *** src/hpsi_pkg.sv ***
// Shared constants and types for host port select and indicator logic
package hpsi_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int STRAP_DELAY_NS = 5000;
    localparam int STRAP_DELAY_CYCLES = (STRAP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int BLINK_MS = 40;
    localparam int BLINK_TICKS = (BLINK_MS * 1000000) / TICK_NS;

    // Indicator control register layout
    localparam int CTRL_WIDTH = 16;
    localparam int CFG_A_LSB = 12;
    localparam int CFG_B_LSB = 8;
    localparam int CFG_WIDTH = 4;

    // Indicator configuration codes
    localparam logic [3:0] IND_OFF = 4'h0;
    localparam logic [3:0] IND_ON = 4'h1;
    localparam logic [3:0] IND_LINK = 4'h2;
    localparam logic [3:0] IND_TX = 4'h3;
    localparam logic [3:0] IND_RX = 4'h4;
    localparam logic [3:0] IND_TXRX = 4'h5;
    localparam logic [3:0] IND_DUPLEX = 4'h6;
    localparam logic [3:0] IND_SPEED = 4'h7;
    localparam logic [3:0] IND_LINK_ACT = 4'h8;
    localparam logic [3:0] IND_BICOLOR_SPEED = 4'hE;
    localparam logic [3:0] IND_BICOLOR_FULL = 4'hF;

    // Reset values
    localparam logic [3:0] CFG_A_RST = IND_LINK;
    localparam logic [3:0] CFG_B_RST = IND_TXRX;

    // Interrupt sources
    localparam int INT_SRC_COUNT = 4;
    localparam int INT_SRC_RX = 0;
    localparam int INT_SRC_TX = 1;
    localparam int INT_SRC_OP = 2;
    localparam int INT_SRC_WAKE = 3;

    // Strap sampling phases
    typedef enum logic [2:0] {
        STRAP_WAIT = 3'b001,
        STRAP_TAKE = 3'b010,
        STRAP_DONE = 3'b100
    } hpsi_strap_e;

endpackage

// *** src/hpsi_strap_sampler.sv ***
// Samples the shared interrupt/select pin once after reset and holds the result
module hpsi_strap_sampler #(
    parameter int DELAY_CYCLES = hpsi_pkg::STRAP_DELAY_CYCLES
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic strap_level,
    output logic serial_selected,
    output logic select_valid,
    output logic pin_release
);
    localparam int CW = $clog2(DELAY_CYCLES + 1);

    hpsi_pkg::hpsi_strap_e state;
    logic [CW-1:0] wait_count;

    if (DELAY_CYCLES < 1) begin : g_bad_delay
        $error("DELAY_CYCLES must be at least one");
    end

    // Phase sequencing; once done nothing but reset leaves it
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state <= hpsi_pkg::STRAP_WAIT;
            wait_count <= '0;
        end else begin
            case (state)
                hpsi_pkg::STRAP_WAIT: begin
                    if (wait_count == CW'(DELAY_CYCLES - 1)) begin
                        state <= hpsi_pkg::STRAP_TAKE;
                    end else begin
                        wait_count <= wait_count + 1'b1;
                    end
                end
                hpsi_pkg::STRAP_TAKE: state <= hpsi_pkg::STRAP_DONE;
                hpsi_pkg::STRAP_DONE: state <= hpsi_pkg::STRAP_DONE;
                default: state <= hpsi_pkg::STRAP_WAIT;
            endcase
        end
    end

    // Single capture of the strap level; later pin activity is ignored
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            serial_selected <= 1'b0;
            select_valid <= 1'b0;
        end else if (state == hpsi_pkg::STRAP_TAKE) begin
            serial_selected <= strap_level;
            select_valid <= 1'b1;
        end
    end

    // Pin stays undriven until the level is captured
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pin_release <= 1'b0;
        end else if (state == hpsi_pkg::STRAP_TAKE) begin
            pin_release <= 1'b1;
        end
    end

endmodule

// *** src/hpsi_stretch.sv ***
// Stretches a one-cycle activity event into a visible indicator pulse
module hpsi_stretch #(
    parameter int TICKS = hpsi_pkg::BLINK_TICKS
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic tick_en,
    input wire logic event_in,
    output logic active
);
    localparam int CW = $clog2(TICKS + 1);

    logic [CW-1:0] remain;

    if (TICKS < 1) begin : g_bad_ticks
        $error("TICKS must be at least one");
    end

    // A new event reloads even while a tick is decrementing
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            remain <= '0;
        end else if (event_in) begin
            remain <= CW'(TICKS);
        end else if (tick_en && remain != '0) begin
            remain <= remain - 1'b1;
        end
    end

    // Registered so the indicator path is glitch free
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            active <= 1'b0;
        end else begin
            active <= event_in || (remain > CW'(1)) || (remain == CW'(1) && !tick_en);
        end
    end

endmodule

// *** sim/hpsi_chk.sv ***
// Concurrent checks on the host port select and indicator top-level ports
module hpsi_chk #(
    parameter int STRAP_CYCLES = 4
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [hpsi_pkg::CTRL_WIDTH-1:0] indicator_control_reg,
    input wire logic link_up,
    input wire logic indicator_a,
    input wire logic indicator_b,
    input wire logic [hpsi_pkg::INT_SRC_COUNT-1:0] int_event,
    input wire logic [hpsi_pkg::INT_SRC_COUNT-1:0] int_enable,
    input wire logic [hpsi_pkg::INT_SRC_COUNT-1:0] int_flags,
    input wire logic int_n_o,
    input wire logic int_n_oe,
    input wire logic serial_enable,
    input wire logic parallel_enable,
    input wire logic spi_cs_n,
    input wire logic spi_so_oe,
    input wire logic par_cs,
    input wire logic par_ad_oe,
    input wire logic par_in_en
);
    timeunit 1ns;
    timeprecision 1ns;
    int unsigned since_rst;

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    // Edges since reset release; saturates so it never wraps in a long run
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            since_rst <= 0;
        end else if (since_rst < 1000) begin
            since_rst <= since_rst + 1;
        end
    end

    property p_one_port; !(serial_enable && parallel_enable); endproperty
    a_one_port: assert property (p_one_port)
        else $error("both host ports enabled");
    property p_strap_early; since_rst <= STRAP_CYCLES + 1 |-> !serial_enable && !parallel_enable;
    endproperty
    a_strap_early: assert property (p_strap_early)
        else $error("host port chosen before the strap delay");
    property p_strap_due; since_rst == STRAP_CYCLES + 2 |-> serial_enable || parallel_enable;
    endproperty
    a_strap_due: assert property (p_strap_due)
        else $error("host port not chosen after the strap delay");
    property p_sel_hold; serial_enable || parallel_enable |=> $stable(serial_enable); endproperty
    a_sel_hold: assert property (p_sel_hold)
        else $error("host port selection changed");
    property p_pin_driven; int_n_oe |=> int_n_oe; endproperty
    a_pin_driven: assert property (p_pin_driven)
        else $error("interrupt pin released after strap");
    property p_int_low; int_n_oe && |(int_flags & int_enable) |=> !int_n_o; endproperty
    a_int_low: assert property (p_int_low)
        else $error("pending interrupt not shown low");
    property p_int_high; int_n_oe && !(|(int_flags & int_enable)) |=> int_n_o; endproperty
    a_int_high: assert property (p_int_high)
        else $error("interrupt pin low with nothing pending");
    property p_flag_set; |int_event |=> (int_flags & $past(int_event)) == $past(int_event);
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("event did not set its flag");
    property p_so_hiz; spi_cs_n |=> !spi_so_oe; endproperty
    a_so_hiz: assert property (p_so_hiz)
        else $error("serial output driven while deselected");
    property p_par_hiz; !par_cs |=> !par_ad_oe; endproperty
    a_par_hiz: assert property (p_par_hiz)
        else $error("parallel pins driven while deselected");
    property p_serial_par_off; serial_enable |-> !par_in_en && !par_ad_oe; endproperty
    a_serial_par_off: assert property (p_serial_par_off)
        else $error("parallel pins active in serial mode");
    property p_link_a; indicator_control_reg[15:12] == 4'h2 |=> indicator_a == $past(link_up);
    endproperty
    a_link_a: assert property (p_link_a)
        else $error("indicator A does not follow link");
    property p_bicolor_off;
        indicator_control_reg[15:8] inside {8'hFF, 8'hEE} && !link_up |=> !indicator_a && !indicator_b;
    endproperty
    a_bicolor_off: assert property (p_bicolor_off)
        else $error("bi-colour lit without link");
endmodule

bind hpsi_top hpsi_chk #(.STRAP_CYCLES(STRAP_CYCLES)) chk_u (
    .clock(clock), .sys_rst(sys_rst), .indicator_control_reg(indicator_control_reg),
    .link_up(link_up), .indicator_a(indicator_a), .indicator_b(indicator_b),
    .int_event(int_event), .int_enable(int_enable), .int_flags(int_flags),
    .int_n_o(int_n_o), .int_n_oe(int_n_oe), .serial_enable(serial_enable),
    .parallel_enable(parallel_enable), .spi_cs_n(spi_cs_n), .spi_so_oe(spi_so_oe),
    .par_cs(par_cs), .par_ad_oe(par_ad_oe), .par_in_en(par_in_en)
);

// *** sim/hpsi_host.sv ***
// Host-side model: strap resistor, shared pin level and data line sources
module hpsi_host (
    input wire logic clock,
    input wire logic strap_high,
    input wire logic int_n_o,
    input wire logic int_n_oe,
    output logic int_pin_i,
    output logic spi_so_data,
    output logic [15:0] par_ad_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] pattern = 16'hA5C3;

    // Host never drives the shared pin, so the strap resistor sets it until the device takes over
    assign int_pin_i = int_n_oe ? int_n_o : strap_high;

    // Odd step makes bit 0 toggle every cycle, so a stale sample never matches
    always @(posedge clock) begin
        pattern <= #1 pattern + 16'h3B5D;
    end
    assign spi_so_data = pattern[0];
    assign par_ad_data = pattern;
endmodule

// *** sim/tb_hpsi_top.sv ***
// Self-checking bench for host port select and indicator logic
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin failures++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end
module tb_hpsi_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int STRAP = 4;
    int failures = 0;
    int checks = 0;
    logic clock = 0, sys_rst = 1, strap_high = 1, cfg_wr = 0, prev;
    logic [15:0] cfg_wdata = 16'h0000, ctrl_reg, par_ad_data, par_ad_o, prev_ad;
    logic strap2 = 1, strap3 = 0;
    logic link_up = 0, speed_100 = 0, full_duplex = 0, tx_act = 0, rx_act = 0;
    logic [3:0] int_event = 4'h0, int_enable = 4'h0, int_clear = 4'h0, int_flags;
    logic ind_a, ind_b, int_pin_i, int_n_o, int_n_oe, serial_enable, parallel_enable;
    logic spi_cs_n = 1, spi_so_data, spi_so_o, spi_so_oe, par_cs = 0, par_read = 0;
    logic par_ad_oe, par_in_en, strap2_q, strap3_q;

    always #20 clock = ~clock;

    hpsi_top #(.TICK_CYCLES(4), .BLINK_TICKS(3), .STRAP_CYCLES(STRAP), .AD_WIDTH(16)) dut_u (
        .clock(clock), .sys_rst(sys_rst), .indicator_cfg_wr(cfg_wr),
        .indicator_cfg_wdata(cfg_wdata), .indicator_control_reg(ctrl_reg),
        .link_up(link_up), .speed_100(speed_100), .full_duplex(full_duplex),
        .tx_activity(tx_act), .rx_activity(rx_act), .indicator_a(ind_a), .indicator_b(ind_b),
        .int_event(int_event), .int_enable(int_enable), .int_clear(int_clear),
        .int_flags(int_flags), .int_pin_i(int_pin_i), .int_n_o(int_n_o), .int_n_oe(int_n_oe),
        .serial_enable(serial_enable), .parallel_enable(parallel_enable),
        .spi_cs_n(spi_cs_n), .spi_so_data(spi_so_data), .spi_so_o(spi_so_o),
        .spi_so_oe(spi_so_oe), .par_cs(par_cs), .par_read(par_read),
        .par_ad_data(par_ad_data), .par_ad_o(par_ad_o), .par_ad_oe(par_ad_oe),
        .par_in_en(par_in_en), .parallel_mode_strap_2(strap2), .parallel_mode_strap_3(strap3),
        .parallel_mode_strap_2_q(strap2_q), .parallel_mode_strap_3_q(strap3_q)
    );

    hpsi_host host_u (
        .clock(clock), .strap_high(strap_high), .int_n_o(int_n_o), .int_n_oe(int_n_oe),
        .int_pin_i(int_pin_i), .spi_so_data(spi_so_data), .par_ad_data(par_ad_data)
    );

    // Inputs always change 2 ns after the rising edge, outputs are read then too
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask

    task automatic reset_dut(input logic high);
        strap_high = high;
        sys_rst = 1;
        step(3);
        `CHK(int_n_oe, 1'b0)
        `CHK(ctrl_reg, 16'h2500)
        sys_rst = 0;
        step(STRAP + 2);
    endtask

    task automatic write_cfg(input logic [15:0] v);
        cfg_wr = 1;
        cfg_wdata = v;
        step(1);
        cfg_wr = 0;
        step(2);
    endtask

    task automatic close_out;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Whole run is under a hundred cycles; this limit only trips on a hang
    initial begin
        #100us;
        failures++;
        close_out();
    end

    initial begin
        reset_dut(1'b1);
        `CHK(serial_enable, 1'b1)
        `CHK(parallel_enable, 1'b0)
        `CHK(int_n_oe, 1'b1)
        `CHK(int_n_o, 1'b1)
        `CHK(par_in_en, 1'b0)
        `CHK(strap2_q, 1'b1)
        `CHK(strap3_q, 1'b0)
        // Power-up indicator modes, no host access at all
        link_up = 1;
        step(2);
        `CHK(ind_a, 1'b1)
        `CHK(ind_b, 1'b0)
        rx_act = 1;
        step(1);
        rx_act = 0;
        step(1);
        `CHK(ind_b, 1'b1)
        // Each interrupt source in turn: set, show on pin, clear
        int_enable = 4'hF;
        for (int i = 0; i < 4; i++) begin
            int_event = 4'h1 << i;
            step(1);
            int_event = 4'h0;
            step(1);
            `CHK(int_flags, 4'h1 << i)
            `CHK(int_n_o, 1'b0)
            int_clear = 4'h1 << i;
            step(1);
            int_clear = 4'h0;
            step(2);
            `CHK(int_flags, 4'h0)
            `CHK(int_n_o, 1'b1)
        end
        // Masked source still visible to a polling host, pin stays high
        int_enable = 4'h0;
        int_event = 4'h4;
        step(1);
        int_event = 4'h0;
        step(2);
        `CHK(int_flags, 4'h4)
        `CHK(int_n_o, 1'b1)
        // Shared pin pulled low by a pending interrupt must not change the choice
        strap_high = 0;
        int_enable = 4'h4;
        step(5);
        `CHK(int_n_o, 1'b0)
        `CHK(serial_enable, 1'b1)
        int_enable = 4'h0;
        // Mode strap inputs stay live in serial mode
        strap2 = 1'b0;
        strap3 = 1'b1;
        step(2);
        `CHK({strap2_q, strap3_q}, 2'b01)
        spi_cs_n = 0;
        step(1);
        prev = spi_so_data;
        step(1);
        `CHK(spi_so_oe, 1'b1)
        `CHK(spi_so_o, prev)
        spi_cs_n = 1;
        step(2);
        `CHK(spi_so_oe, 1'b0)
        // Bi-colour, speed and duplex code
        speed_100 = 1;
        full_duplex = 1;
        write_cfg(16'hFF00);
        `CHK(ctrl_reg, 16'hFF00)
        `CHK(ind_b, 1'b1)
        `CHK(ind_a, 1'b0)
        tx_act = 1;
        step(1);
        tx_act = 0;
        step(1);
        `CHK({ind_a, ind_b}, 2'b00)
        step(20);
        // Speed-only code; low byte of the write is dropped
        full_duplex = 0;
        write_cfg(16'hEE0F);
        `CHK(ctrl_reg, 16'hEE00)
        `CHK({ind_a, ind_b}, 2'b01)
        speed_100 = 0;
        step(2);
        `CHK({ind_a, ind_b}, 2'b10)
        link_up = 0;
        step(2);
        `CHK({ind_a, ind_b}, 2'b00)
        // Second power-up with the strap pulled low
        reset_dut(1'b0);
        `CHK(parallel_enable, 1'b1)
        `CHK(serial_enable, 1'b0)
        `CHK(par_in_en, 1'b1)
        par_read = 1;
        spi_cs_n = 0;
        step(2);
        `CHK(par_ad_oe, 1'b0)
        `CHK(spi_so_oe, 1'b0)
        par_cs = 1;
        step(1);
        prev_ad = par_ad_data;
        step(1);
        `CHK(par_ad_oe, 1'b1)
        `CHK(par_ad_o, prev_ad)
        par_cs = 0;
        step(2);
        `CHK(par_ad_oe, 1'b0)
        close_out();
    end
endmodule
